// ===== hbs_chk.sv
// holding brake sequencer: port checker bound into hbs_top
// assumes one clock domain, nrst asynchronous and active low
`timescale 1ns/100ps
module hbs_chk (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // register bus
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_rvalid,
  // motion and power
  input wire motor_standstill,
  input wire motion_en,
  input wire stop_req,
  input wire motor_current_en
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // full-word write taken at this edge
  wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_wstrb == 4'hf;
  property p_run_cur; motion_en |-> motor_current_en && !stop_req; endproperty
  a_run_cur: assert property (p_run_cur)
    else $error("motion allowed without current");
  property p_stop_cur; stop_req |-> motor_current_en && !motion_en; endproperty
  a_stop_cur: assert property (p_stop_cur)
    else $error("stop request without current");
  property p_stop_end; $fell(stop_req) |-> $past(motor_standstill); endproperty
  a_stop_end: assert property (p_stop_end)
    else $error("stop ended before standstill");
  property p_off; $fell(motor_current_en) |-> !$past(motion_en) && !$past(stop_req); endproperty
  a_off: assert property (p_off)
    else $error("current cut while moving");
  property p_rise; $rose(motion_en) |-> $past(motor_current_en, 2); endproperty
  a_rise: assert property (p_rise)
    else $error("motion before current settled");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_freq; wr_take && s_axi_awaddr == 8'h1c
    |=> s_axi_bresp == (($past(s_axi_wdata) > 32'd20000) ? 2'b10 : 2'b00); endproperty
  a_freq: assert property (p_freq)
    else $error("frequency limit wrong");
  property p_duty; wr_take && s_axi_awaddr == 8'h20 |=> s_axi_bvalid
    && s_axi_bresp == (($past(s_axi_wdata) < 32'd2 || $past(s_axi_wdata) > 32'd100)
    ? 2'b10 : 2'b00); endproperty
  a_duty: assert property (p_duty)
    else $error("duty limit wrong");
  property p_rd; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd)
    else $error("read not answered");
endmodule
bind hbs_top hbs_chk hbs_chk_inst (.sys_clk(sys_clk), .nrst(nrst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_rvalid(s_axi_rvalid), .motor_standstill(motor_standstill), .motion_en(motion_en),
  .stop_req(stop_req), .motor_current_en(motor_current_en));

// ===== hbs_delay.v
// holding brake sequencer: millisecond delay timer
// assumes start is a one-cycle pulse from the sequencer
`timescale 1ns/100ps
module hbs_delay #(
  parameter CYC_PER_MS = 100000
) (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // control
  input wire start,
  input wire [15:0] ms_val,
  // result
  output reg done
);

  reg [31:0] pre_r;
  reg [15:0] cnt_r;
  reg busy_r;
  wire tick;

  // prescaler restarts with every count so a step gets its full time
  assign tick = (pre_r == CYC_PER_MS - 1);

  // ************************************************************
  // count down whole milliseconds
  // ************************************************************
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pre_r <= 32'h0;
      cnt_r <= 16'h0;
      busy_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        pre_r <= 32'h0;
        cnt_r <= ms_val;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r == 16'h0) begin
          busy_r <= 1'b0;
          done <= 1'b1;
        end else if (tick) begin
          pre_r <= 32'h0;
          cnt_r <= cnt_r - 16'h1;
        end else begin
          pre_r <= pre_r + 32'h1;
        end
      end
    end
  end

endmodule

// ===== hbs_map.vh
// holding brake sequencer: register offsets, field positions, resets, timing
// assumes a 100 MHz system clock and a 32-bit register bus
`ifndef HBS_MAP_VH
`define HBS_MAP_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define HBS_OFF_SUBMODE 8'h00
`define HBS_OFF_DOUT 8'h04
`define HBS_OFF_CTRL 8'h08
`define HBS_OFF_T1 8'h0c
`define HBS_OFF_T2 8'h10
`define HBS_OFF_T3 8'h14
`define HBS_OFF_T4 8'h18
`define HBS_OFF_FREQ 8'h1c
`define HBS_OFF_DUTY 8'h20
`define HBS_OFF_STATUS 8'h24

// ************************************************************
// field positions
// ************************************************************
`define HBS_SUB_AUTO_BIT 2
`define HBS_DOUT_BRAKE_BIT 0
`define HBS_CTRL_EN_BIT 0

// ************************************************************
// reset values and limits
// ************************************************************
`define HBS_RST_SUBMODE 32'h0000_0004
`define HBS_RST_DOUT 32'h0000_0000
`define HBS_RST_DELAY 16'h000a
`define HBS_RST_FREQ 15'h03e8
`define HBS_RST_DUTY 7'h64
`define HBS_FREQ_MAX 15'h4e20
`define HBS_DUTY_MIN 7'h02
`define HBS_DUTY_MAX 7'h64

// ************************************************************
// timing
// ************************************************************
`define HBS_CLK_PERIOD_NS 10
`define HBS_TICK_NS 1000000
`define HBS_CLK_HZ 27'h5f5_e100
`define HBS_PCT_STEP 20'hf_4240

// ************************************************************
// response codes and sequencer states
// ************************************************************
`define HBS_RESP_OKAY 2'b00
`define HBS_RESP_SLVERR 2'b10
`define HBS_RESP_DECERR 2'b11
`define HBS_ST_IDLE 3'd0
`define HBS_ST_CUR_ON 3'd1
`define HBS_ST_SETTLE 3'd2
`define HBS_ST_RUN 3'd3
`define HBS_ST_STOPPING 3'd4
`define HBS_ST_HOLD 3'd5
`define HBS_ST_ENGAGE 3'd6

`endif

// ===== hbs_motor.sv
// holding brake sequencer: motion core and motor stand-in
// assumes motion_en and stop_req are levels from hbs_top
`timescale 1ns/100ps
module hbs_motor (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // commands from the sequencer
  input wire motion_en,
  input wire stop_req,
  input wire [7:0] stop_cyc,
  // status back
  output reg motor_standstill
);
  reg [7:0] cnt_r;
  // moves while allowed; coasts stop_cyc cycles only while told to stop
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 8'h00;
      motor_standstill <= 1'b1;
    end else if (motion_en) begin
      cnt_r <= stop_cyc;
      motor_standstill <= 1'b0;
    end else if (stop_req && cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end else if (cnt_r == 8'h00) begin
      motor_standstill <= 1'b1;
    end
  end
endmodule

// ===== hbs_pwm.v
// holding brake sequencer: brake pwm generator
// assumes freq and duty already checked; new values used at period end while active at nonzero frequency
`timescale 1ns/100ps
`include "hbs_map.vh"
module hbs_pwm (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // settings
  input wire [14:0] freq_hz,
  input wire [6:0] duty_pct,
  // brake energised; an idle output has no period to disturb
  input wire active,
  // waveform
  output reg pwm
);

  reg [26:0] phase_r;
  reg [14:0] freq_r;
  reg [6:0] duty_r;
  wire [27:0] sum;
  wire wrap;
  wire [26:0] high_lim;

  // phase accumulator avoids a divider: one period is CLK_HZ of phase
  assign sum = {1'b0, phase_r} + {13'h0, freq_r};
  assign wrap = (sum >= {1'b0, `HBS_CLK_HZ});
  assign high_lim = {20'h0, duty_r} * {7'h0, `HBS_PCT_STEP};

  // ************************************************************
  // phase, settings latch and compare
  // ************************************************************
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= 27'h0;
      freq_r <= `HBS_RST_FREQ;
      duty_r <= `HBS_RST_DUTY;
      pwm <= 1'b0;
    end else begin
      if (wrap) begin
        phase_r <= sum[26:0] - `HBS_CLK_HZ;
      end else begin
        phase_r <= sum[26:0];
      end
      // idle or zero frequency loads at once, else a slow period could lock it
      if (wrap | ~active | (freq_r == 15'h0)) begin
        freq_r <= freq_hz; // [R11]
        duty_r <= duty_pct; // [R11]
      end
      // duty 100 gives a limit above any phase: steady high [R9]
      pwm <= (phase_r < high_lim); // [R2]
    end
  end

endmodule

// ===== hbs_top.v
// holding brake sequencer with brake pwm and axi4-lite registers
// assumes the motion core reports standstill and obeys motion_en/stop_req
// Functional notes
// (R1) auto mode: brake engaged everywhere except operation-enabled sequencing
// (R2) energised brake output is pwm with configured frequency and duty
// (R3) submode bit 2 set selects automatic brake control
// (R4) submode bit 2 clear: brake follows output control bit 0
// (R5) enable: current on, wait t3, release brake, wait t4, allow motion
// (R6) disable: stop motor, wait t1, engage brake, wait t2, current off
// (R7) pwm frequency in hertz, values above 20000 refused
// (R8) duty in percent, only 2 to 100 accepted
// (R9) duty 100 holds brake output steadily on
// (R10) auto control drives output control bit 0 as brake command
// (R11) pwm from free-running counter, settings applied at period end; code loads them at once while idle or at zero frequency
// (R12) delays counted in ms ticks, each started after previous step
`timescale 1ns/100ps
`include "hbs_map.vh"
module hbs_top #(
  parameter CYC_PER_MS = `HBS_TICK_NS / `HBS_CLK_PERIOD_NS
) (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // axi4-lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // motion core
  input wire motor_standstill,
  output reg motion_en,
  output reg stop_req,
  // power stage and brake
  output reg motor_current_en,
  output reg brake_out,
  output reg brake_cmd
);

  // ************************************************************
  // registers
  // ************************************************************
  reg [31:0] submode_r;
  reg [31:0] dout_r;
  reg en_req_r;
  reg [15:0] t1_r;
  reg [15:0] t2_r;
  reg [15:0] t3_r;
  reg [15:0] t4_r;
  reg [14:0] freq_r;
  reg [6:0] duty_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg seq_open_r;
  reg tmr_start;
  reg [15:0] tmr_val;
  wire tmr_done;
  wire pwm_raw;
  wire auto_mode;
  wire brake_energised;
  wire wr_go;
  wire rd_go;
  wire [31:0] old_word;
  wire [31:0] wmask;
  wire [31:0] wval;
  reg wr_hit;
  reg wr_bad;
  reg [31:0] rd_word;
  reg rd_hit;
  // readable words, lowest offset last; a function reading regs itself hides them from @*
  wire [319:0] all_words = {{24'h0, brake_out, brake_energised, stop_req, motion_en,
    motor_current_en, state_r}, {25'h0, duty_r}, {17'h0, freq_r}, {16'h0, t4_r},
    {16'h0, t3_r}, {16'h0, t2_r}, {16'h0, t1_r}, {31'h0, en_req_r},
    {dout_r[31:1], brake_cmd}, submode_r}; // [R10]

  assign auto_mode = submode_r[`HBS_SUB_AUTO_BIT]; // [R3]
  // manual mode takes the software bit, auto mode the sequencer [R4]
  assign brake_energised = auto_mode ? seq_open_r : dout_r[`HBS_DOUT_BRAKE_BIT];

  // ************************************************************
  // bus handshake: write takes address and data together
  // ************************************************************
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_go;

  // byte lanes merged onto the current value before checking
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign old_word = rd_word_of(s_axi_awaddr, all_words);
  assign wval = (old_word & ~wmask) | (s_axi_wdata & wmask);

  // readback word for an offset; dout bit 0 shows the live command
  function [31:0] rd_word_of;
    input [7:0] a;
    input [319:0] w;
    begin
      case (a)
        `HBS_OFF_SUBMODE: rd_word_of = w[31:0];
        `HBS_OFF_DOUT: rd_word_of = w[63:32]; // [R10]
        `HBS_OFF_CTRL: rd_word_of = w[95:64];
        `HBS_OFF_T1: rd_word_of = w[127:96];
        `HBS_OFF_T2: rd_word_of = w[159:128];
        `HBS_OFF_T3: rd_word_of = w[191:160];
        `HBS_OFF_T4: rd_word_of = w[223:192];
        `HBS_OFF_FREQ: rd_word_of = w[255:224];
        `HBS_OFF_DUTY: rd_word_of = w[287:256];
        `HBS_OFF_STATUS: rd_word_of = w[319:288];
        default: rd_word_of = 32'h0;
      endcase
    end
  endfunction

  // decode: unmapped gives decerr, out-of-range settings slverr
  always @* begin
    wr_hit = 1'b1;
    wr_bad = 1'b0;
    case (s_axi_awaddr)
      `HBS_OFF_SUBMODE, `HBS_OFF_DOUT, `HBS_OFF_CTRL: wr_bad = 1'b0;
      `HBS_OFF_T1, `HBS_OFF_T2, `HBS_OFF_T3, `HBS_OFF_T4: wr_bad = 1'b0;
      `HBS_OFF_FREQ: wr_bad = (wval > {17'h0, `HBS_FREQ_MAX}); // [R7]
      `HBS_OFF_DUTY: wr_bad = (wval < {25'h0, `HBS_DUTY_MIN}) |
                              (wval > {25'h0, `HBS_DUTY_MAX}); // [R8]
      `HBS_OFF_STATUS: wr_bad = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always @* begin
    rd_hit = 1'b1;
    rd_word = rd_word_of(s_axi_araddr, all_words);
    case (s_axi_araddr)
      `HBS_OFF_SUBMODE, `HBS_OFF_DOUT, `HBS_OFF_CTRL, `HBS_OFF_T1: rd_hit = 1'b1;
      `HBS_OFF_T2, `HBS_OFF_T3, `HBS_OFF_T4, `HBS_OFF_FREQ: rd_hit = 1'b1;
      `HBS_OFF_DUTY, `HBS_OFF_STATUS: rd_hit = 1'b1;
      default: rd_hit = 1'b0;
    endcase
  end

  // ************************************************************
  // register writes and write response
  // ************************************************************
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      submode_r <= `HBS_RST_SUBMODE;
      dout_r <= `HBS_RST_DOUT;
      en_req_r <= 1'b0;
      t1_r <= `HBS_RST_DELAY;
      t2_r <= `HBS_RST_DELAY;
      t3_r <= `HBS_RST_DELAY;
      t4_r <= `HBS_RST_DELAY;
      freq_r <= `HBS_RST_FREQ;
      duty_r <= `HBS_RST_DUTY;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HBS_RESP_OKAY;
    end else begin
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (!wr_hit) begin
          s_axi_bresp <= `HBS_RESP_DECERR;
        end else if (wr_bad) begin
          // refused value leaves the old setting in place
          s_axi_bresp <= `HBS_RESP_SLVERR;
        end else begin
          s_axi_bresp <= `HBS_RESP_OKAY;
          case (s_axi_awaddr)
            `HBS_OFF_SUBMODE: submode_r <= wval;
            `HBS_OFF_DOUT: dout_r <= wval;
            `HBS_OFF_CTRL: en_req_r <= wval[`HBS_CTRL_EN_BIT];
            `HBS_OFF_T1: t1_r <= wval[15:0];
            `HBS_OFF_T2: t2_r <= wval[15:0];
            `HBS_OFF_T3: t3_r <= wval[15:0];
            `HBS_OFF_T4: t4_r <= wval[15:0];
            `HBS_OFF_FREQ: freq_r <= wval[14:0]; // [R7]
            `HBS_OFF_DUTY: duty_r <= wval[6:0]; // [R8]
            default: en_req_r <= en_req_r;
          endcase
        end
      end
    end
  end

  // ************************************************************
  // read response
  // ************************************************************
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `HBS_RESP_OKAY;
    end else begin
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_hit ? rd_word : 32'h0;
        s_axi_rresp <= rd_hit ? `HBS_RESP_OKAY : `HBS_RESP_DECERR;
      end
    end
  end

  // ************************************************************
  // power sequencer
  // ************************************************************
  // each timer start is raised on the step that ends the last one, or on the abort out of HBS_ST_CUR_ON
  always @* begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    tmr_val = 16'h0;
    case (state_r)
      `HBS_ST_IDLE: begin
        if (en_req_r) begin
          state_nxt = `HBS_ST_CUR_ON; // [R5]
          tmr_start = 1'b1;
          tmr_val = t3_r;
        end
      end
      `HBS_ST_CUR_ON: begin
        if (!en_req_r) begin
          // brake never opened: just wait out the engage time
          state_nxt = `HBS_ST_ENGAGE;
          tmr_start = 1'b1;
          tmr_val = t2_r;
        end else if (tmr_done) begin
          state_nxt = `HBS_ST_SETTLE; // [R5]
          tmr_start = 1'b1; // [R12]
          tmr_val = t4_r;
        end
      end
      `HBS_ST_SETTLE: begin
        if (!en_req_r) begin
          state_nxt = `HBS_ST_STOPPING;
        end else if (tmr_done) begin
          state_nxt = `HBS_ST_RUN; // [R5]
        end
      end
      `HBS_ST_RUN: begin
        if (!en_req_r) begin
          state_nxt = `HBS_ST_STOPPING; // [R6]
        end
      end
      `HBS_ST_STOPPING: begin
        if (motor_standstill) begin
          state_nxt = `HBS_ST_HOLD; // [R6]
          tmr_start = 1'b1; // [R12]
          tmr_val = t1_r;
        end
      end
      `HBS_ST_HOLD: begin
        if (tmr_done) begin
          state_nxt = `HBS_ST_ENGAGE; // [R6]
          tmr_start = 1'b1; // [R12]
          tmr_val = t2_r;
        end
      end
      `HBS_ST_ENGAGE: begin
        if (tmr_done) begin
          state_nxt = `HBS_ST_IDLE; // [R6]
        end
      end
      default: state_nxt = `HBS_ST_IDLE;
    endcase
  end

  // outputs registered from the next state so they track it exactly
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= `HBS_ST_IDLE;
      motor_current_en <= 1'b0;
      seq_open_r <= 1'b0;
      motion_en <= 1'b0;
      stop_req <= 1'b0;
    end else begin
      state_r <= state_nxt;
      motor_current_en <= (state_nxt != `HBS_ST_IDLE); // [R5] [R6]
      // brake opens only inside the operation-enabled sequence [R1]
      seq_open_r <= (state_nxt == `HBS_ST_SETTLE) | (state_nxt == `HBS_ST_RUN) |
                    (state_nxt == `HBS_ST_STOPPING) | (state_nxt == `HBS_ST_HOLD);
      motion_en <= (state_nxt == `HBS_ST_RUN); // [R5]
      stop_req <= (state_nxt == `HBS_ST_STOPPING); // [R6]
    end
  end

  // ************************************************************
  // brake output stage
  // ************************************************************
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      brake_out <= 1'b0;
      brake_cmd <= 1'b0;
    end else begin
      brake_cmd <= brake_energised; // [R10]
      brake_out <= brake_energised & pwm_raw; // [R2] [R1] [R4]
    end
  end

  hbs_delay #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_delay (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(tmr_start),
    .ms_val(tmr_val),
    .done(tmr_done)
  );

  hbs_pwm u_pwm (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .freq_hz(freq_r),
    .duty_pct(duty_r),
    .active(brake_energised),
    .pwm(pwm_raw)
  );

endmodule

// ===== holding_brake_sequencer_pwm_test.sv
// holding brake sequencer: self-checking testbench
// assumes CYC_PER_MS of 10, so one ms delay is ten clock cycles
`timescale 1ns/100ps
module holding_brake_sequencer_pwm_test;
  reg sys_clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, val;
  reg [3:0] wstrb;
  reg [1:0] resp;
  wire awready, wready, bvalid, arready, rvalid, still, motion_en, stop_req;
  wire cur_en, brake_out, brake_cmd;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer miscompares, checked, n, rises, i;
  reg prev;
  // ************************************************************
  // design and partner
  // ************************************************************
  hbs_top #(.CYC_PER_MS(10)) hbs_top_inst (.sys_clk(sys_clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .motor_standstill(still), .motion_en(motion_en), .stop_req(stop_req),
    .motor_current_en(cur_en), .brake_out(brake_out), .brake_cmd(brake_cmd));
  hbs_motor hbs_motor_inst (.sys_clk(sys_clk), .nrst(nrst), .motion_en(motion_en),
    .stop_req(stop_req), .stop_cyc(8'd20), .motor_standstill(still));
  // ************************************************************
  // helpers
  // ************************************************************
  always #5 sys_clk = ~sys_clk;
  task chk(input [31:0] got, input [31:0] exp, input string what);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: %0s got %0h", $time, what, got);
      end
    end
  endtask
  task chk_rng(input integer got, input integer lo, input integer hi, input string what);
    begin
      checked = checked + 1;
      if (got < lo || got > hi) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: %0s got %0d", $time, what, got);
      end
    end
  endtask
  // write; ready is combinational, so looking at it on the edge is safe
  task wr(input [7:0] a, input [31:0] d, input [3:0] s);
    begin
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      @(posedge sys_clk);
      while (!awready) @(posedge sys_clk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      // bready a cycle late, so the response must stand and wait
      @(posedge sys_clk);
      bready <= 1'b1;
      @(posedge sys_clk);
      while (!bvalid) @(posedge sys_clk);
      resp = bresp;
      bready <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task rd(input [7:0] a);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge sys_clk);
      while (!arready) @(posedge sys_clk);
      arvalid <= 1'b0;
      @(posedge sys_clk);
      while (!rvalid) @(posedge sys_clk);
      val = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  // counts high cycles and rising edges of the brake pin
  task cnt_hi(input integer m);
    begin
      n = 0;
      rises = 0;
      prev = brake_out;
      repeat (m) begin
        @(posedge sys_clk);
        if (brake_out === 1'b1) n = n + 1;
        if (brake_out === 1'b1 && prev === 1'b0) rises = rises + 1;
        prev = brake_out;
      end
    end
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task t_regs;
    begin
      rd(8'h00);
      chk(val, 32'h4, "submode reset");
      rd(8'h1c);
      chk(val, 32'h3e8, "freq reset");
      rd(8'h20);
      chk(val, 32'h64, "duty reset");
      rd(8'h3c);
      chk(resp, 2'b11, "unmapped read");
      $display("test regs done");
    end
  endtask
  task t_limits;
    begin
      wr(8'h1c, 32'd20001, 4'hf);
      chk(resp, 2'b10, "freq over");
      wr(8'h1c, 32'd20000, 4'hf);
      chk(resp, 2'b00, "freq max");
      wr(8'h1c, 32'h000000ff, 4'h1);
      chk(resp, 2'b10, "merged freq over");
      wr(8'h20, 32'd1, 4'hf);
      chk(resp, 2'b10, "duty under");
      wr(8'h20, 32'd101, 4'hf);
      chk(resp, 2'b10, "duty over");
      wr(8'h20, 32'd2, 4'hf);
      chk(resp, 2'b00, "duty min");
      rd(8'h1c);
      chk(val, 32'd20000, "freq kept");
      wr(8'h24, 32'h0, 4'hf);
      chk(resp, 2'b10, "status write");
      wr(8'h3c, 32'h0, 4'hf);
      chk(resp, 2'b11, "unmapped write");
      $display("test limits done");
    end
  endtask
  task t_auto;
    begin
      wr(8'h20, 32'd100, 4'hf);
      wr(8'h00, 32'h4, 4'hf);
      wr(8'h04, 32'h1, 4'hf);
      wr(8'h0c, 32'd1, 4'hf);
      wr(8'h10, 32'd2, 4'hf);
      wr(8'h14, 32'd2, 4'hf);
      wr(8'h18, 32'd3, 4'hf);
      cnt_hi(20);
      chk_rng(n, 0, 0, "brake idle");
      wr(8'h08, 32'h1, 4'hf);
      chk(cur_en, 1'b1, "current on");
      n = 0;
      while (brake_out !== 1'b1) begin
        @(posedge sys_clk);
        n = n + 1;
      end
      chk_rng(n, 17, 27, "release delay");
      n = 0;
      while (motion_en !== 1'b1) begin
        @(posedge sys_clk);
        n = n + 1;
      end
      chk_rng(n, 28, 36, "settle delay");
      cnt_hi(50);
      chk_rng(n, 50, 50, "steady brake");
      rd(8'h04);
      chk(val & 32'h1, 32'h1, "brake command bit");
      chk(brake_cmd, 1'b1, "brake command pin");
      wr(8'h08, 32'h0, 4'hf);
      chk(stop_req, 1'b1, "stop request");
      n = 0;
      while (brake_out === 1'b1) begin
        @(posedge sys_clk);
        n = n + 1;
      end
      chk_rng(n, 28, 42, "hold delay");
      n = 0;
      while (cur_en === 1'b1) begin
        @(posedge sys_clk);
        n = n + 1;
      end
      chk_rng(n, 18, 26, "engage delay");
      rd(8'h24);
      chk(val & 32'h7, 32'h0, "back to idle");
      $display("test auto done");
    end
  endtask
  // enable dropped before the brake opens: straight to engage time
  task t_abort;
    begin
      wr(8'h08, 32'h1, 4'hf);
      wr(8'h08, 32'h0, 4'hf);
      n = 0;
      rises = 0;
      while (cur_en === 1'b1) begin
        @(posedge sys_clk);
        n = n + 1;
        if (brake_out !== 1'b0) rises = rises + 1;
      end
      chk_rng(n, 18, 26, "abort engage delay");
      chk_rng(rises, 0, 0, "brake kept closed");
      $display("test abort done");
    end
  endtask
  task t_pwm;
    begin
      wr(8'h00, 32'h0, 4'hf);
      wr(8'h1c, 32'd20000, 4'hf);
      for (i = 0; i < 4; i = i + 1) begin
        wr(8'h20, (i == 3) ? 32'd100 : 32'd2 + i * 24, 4'hf);
        repeat (5010) @(posedge sys_clk);
        cnt_hi(10000);
        chk_rng(n, (i == 3) ? 10000 : 198 + i * 2400, (i == 3) ? 10000 : 202 + i * 2400,
          "high time");
        chk_rng(rises, (i == 3) ? 0 : 2, (i == 3) ? 0 : 2, "period count");
      end
      wr(8'h04, 32'h0, 4'hf);
      cnt_hi(200);
      chk_rng(n, 0, 0, "manual off");
      $display("test pwm done");
    end
  endtask
  // ************************************************************
  // run control
  // ************************************************************
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // about 61k cycles of tests; the watchdog allows 100k
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    complete_run;
  end
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb} = 20'h00000;
    wdata = 32'h0;
    miscompares = 0;
    checked = 0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_regs;
    t_limits;
    t_auto;
    t_abort;
    t_pwm;
    complete_run;
  end
endmodule
